// file: verilog/gjk_pkg.sv
package gjk_pkg;
  // synchroniser depth for the clock, preset and clear pin inputs
  localparam int SYNC_DEPTH = 2;
  // gate vector layout: three set terms, then three clear terms
  localparam int GATE_W     = 6;
  localparam int G_SET_A    = 0;
  localparam int G_SET_B    = 1;
  localparam int G_SET_INV  = 2;
  localparam int G_CLR_A    = 3;
  localparam int G_CLR_B    = 4;
  localparam int G_CLR_INV  = 5;
  // reset values; preset and clear sync stages reset to the idle level
  localparam logic [1:0] SYNC_IDLE_LOW  = 2'h0;
  localparam logic [1:0] SYNC_IDLE_HIGH = 2'h3;
  localparam logic [5:0] GATE_RESET     = 6'h00;
  localparam logic       STATE_RESET    = 1'h0;
  localparam logic       TRUE_RESET     = 1'h0;
  localparam logic       COMPL_RESET    = 1'h1;
endpackage

// file: verilog/gjk_flip_flop.sv
`timescale 1ns/100ps
// Notes on behaviour
// - gated J and K sampled, state updated, only on rising edge of element clock
// - after a clock edge inputs lock out; state changes at most once per pulse
// - active-low set and clear act regardless of element clock edges
// - set low with clear high and clock low forces the true output high
// - clear low forces the true output low
// - set or clear with clock high may drive both outputs low
// - effective J is AND of true J inputs and inverted J input; K likewise
// - stored state kept apart from outputs; loading cannot disturb it
module gjk_flip_flop
  import gjk_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ff_clock,
  input  wire logic set_gate_a,
  input  wire logic set_gate_b,
  input  wire logic set_gate_inv_n,
  input  wire logic clear_gate_a,
  input  wire logic clear_gate_b,
  input  wire logic clear_gate_inv_n,
  input  wire logic preset_n,
  input  wire logic clear_n,
  output logic      q_true,
  output logic      q_compl
);

  typedef struct packed {
    logic [SYNC_DEPTH-1:0] clk_sync;
    logic [SYNC_DEPTH-1:0] pre_sync;
    logic [SYNC_DEPTH-1:0] clr_sync;
    logic [GATE_W-1:0]     gate_s1;
    logic [GATE_W-1:0]     gate_s2;
    logic                  clk_prev;
    logic                  lockout;
    logic                  stored;
    logic                  q_true;
    logic                  q_compl;
  } gjk_state_type;

  gjk_state_type state_reg;
  gjk_state_type state_next;

  logic clk_hi;
  logic pre_act;
  logic clr_act;
  logic async_act;
  logic j_eff;
  logic k_eff;
  logic take;
  logic jk_next;

  // only the second sync stage and later flops are looked at here
  assign clk_hi    = state_reg.clk_sync[SYNC_DEPTH-1];
  assign pre_act   = ~state_reg.pre_sync[SYNC_DEPTH-1];
  assign clr_act   = ~state_reg.clr_sync[SYNC_DEPTH-1];
  assign async_act = pre_act | clr_act;
  assign j_eff     = state_reg.gate_s2[G_SET_A] & state_reg.gate_s2[G_SET_B]
                   & ~state_reg.gate_s2[G_SET_INV];
  assign k_eff     = state_reg.gate_s2[G_CLR_A] & state_reg.gate_s2[G_CLR_B]
                   & ~state_reg.gate_s2[G_CLR_INV];
  // a rise is taken once; lockout holds until the clock is low again
  assign take      = clk_hi & ~state_reg.clk_prev & ~state_reg.lockout;

  always_comb begin
    case ({j_eff, k_eff})
      2'h0:    jk_next = state_reg.stored;
      2'h1:    jk_next = 1'h0;
      2'h2:    jk_next = 1'h1;
      2'h3:    jk_next = ~state_reg.stored;
      default: jk_next = state_reg.stored;
    endcase
  end

  always_comb begin
    state_next          = state_reg;
    state_next.clk_sync = {state_reg.clk_sync[SYNC_DEPTH-2:0], ff_clock};
    state_next.pre_sync = {state_reg.pre_sync[SYNC_DEPTH-2:0], preset_n};
    state_next.clr_sync = {state_reg.clr_sync[SYNC_DEPTH-2:0], clear_n};
    state_next.gate_s1  = {clear_gate_inv_n, clear_gate_b, clear_gate_a,
                           set_gate_inv_n, set_gate_b, set_gate_a};
    state_next.gate_s2  = state_reg.gate_s1;
    state_next.clk_prev = clk_hi;
    state_next.lockout  = clk_hi;
    // clear wins when both are low; neither waits for a clock edge
    if (clr_act) begin
      state_next.stored = 1'h0;
    end else if (pre_act) begin
      state_next.stored = 1'h1;
    end else if (take) begin
      state_next.stored = jk_next;
    end
    // outputs are separate flops so nothing downstream reaches the stored bit
    if (async_act && clk_hi) begin
      state_next.q_true  = 1'h0;
      state_next.q_compl = 1'h0;
    end else begin
      state_next.q_true  = state_next.stored;
      state_next.q_compl = ~state_next.stored;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg.clk_sync <= SYNC_IDLE_LOW;
      state_reg.pre_sync <= SYNC_IDLE_HIGH;
      state_reg.clr_sync <= SYNC_IDLE_HIGH;
      state_reg.gate_s1  <= GATE_RESET;
      state_reg.gate_s2  <= GATE_RESET;
      state_reg.clk_prev <= 1'h0;
      state_reg.lockout  <= 1'h0;
      state_reg.stored   <= STATE_RESET;
      state_reg.q_true   <= TRUE_RESET;
      state_reg.q_compl  <= COMPL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_true  = state_reg.q_true;
  assign q_compl = state_reg.q_compl;

  sequence seq_pin_rise;
    !ff_clock ##1 ff_clock ##1 ff_clock ##1 ff_clock;
  endsequence

  sequence seq_toggle_edge;
    take && j_eff && k_eff && !async_act;
  endsequence

  // an edge that no preset or clear overrides
  sequence seq_edge_quiet;
    take && !async_act;
  endsequence

  // the both-low window closes when preset, clear or the clock lets go
  sequence seq_async_release;
    (async_act && clk_hi) ##1 !(async_act && clk_hi);
  endsequence

  AST_RISE_TAKEN: assert property (@(posedge clk) disable iff (!rstn)
    seq_pin_rise |-> take)
    else $error("clock pin rise not taken three cycles later");

  AST_ONE_PER_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    take |=> !take)
    else $error("second update within one clock pulse");

  AST_LOCKED_HIGH: assert property (@(posedge clk) disable iff (!rstn)
    (clk_hi && state_reg.clk_prev) |-> !take)
    else $error("edge taken while clock pin stayed high");

  AST_CHANGE_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg.stored != $past(state_reg.stored)) |-> $past(take || async_act))
    else $error("stored state changed without edge or preset");

  AST_PRESET_HIGH: assert property (@(posedge clk) disable iff (!rstn)
    (pre_act && !clr_act && !clk_hi) |=> (state_reg.stored && q_true && !q_compl))
    else $error("preset did not force true output high");

  AST_CLEAR_LOW: assert property (@(posedge clk) disable iff (!rstn)
    clr_act |=> (!state_reg.stored && !q_true))
    else $error("clear did not force true output low");

  AST_BOTH_LOW: assert property (@(posedge clk) disable iff (!rstn)
    (async_act && clk_hi) |=> (!q_true && !q_compl))
    else $error("outputs not both low on preset with clock high");

  AST_COMPLEMENT: assert property (@(posedge clk) disable iff (!rstn)
    (q_true == q_compl) |-> $past(async_act && clk_hi))
    else $error("complement output not inverse of true output");

  AST_ISOLATED: assert property (@(posedge clk) disable iff (!rstn)
    (q_true || q_compl) |-> (q_true == state_reg.stored))
    else $error("true output differs from stored state");

  AST_TOGGLE: assert property (@(posedge clk) disable iff (!rstn)
    seq_toggle_edge |=> (state_reg.stored != $past(state_reg.stored)))
    else $error("toggle edge did not invert state");

  AST_GATED_SET: assert property (@(posedge clk) disable iff (!rstn)
    (take && !async_act && !k_eff) |=>
      (state_reg.stored == ($past(j_eff) | $past(state_reg.stored))))
    else $error("set term not applied on edge");

  AST_HOLD_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    (seq_edge_quiet ##0 (!j_eff && !k_eff)) |=>
      (state_reg.stored == $past(state_reg.stored)))
    else $error("hold edge changed the state");

  AST_GATED_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    (seq_edge_quiet ##0 (!j_eff && k_eff)) |=> !state_reg.stored)
    else $error("clear term not applied on edge");

  AST_SET_INV_BLOCKS: assert property (@(posedge clk) disable iff (!rstn)
    (seq_edge_quiet ##0 (state_reg.gate_s2[G_SET_INV] && !k_eff)) |=>
      (state_reg.stored == $past(state_reg.stored)))
    else $error("inverting set input did not block the set term");

  AST_CLR_INV_BLOCKS: assert property (@(posedge clk) disable iff (!rstn)
    (seq_edge_quiet ##0 (state_reg.gate_s2[G_CLR_INV] && !j_eff)) |=>
      (state_reg.stored == $past(state_reg.stored)))
    else $error("inverting clear input did not block the clear term");

  AST_NO_EDGE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (!take && !async_act) |=> (state_reg.stored == $past(state_reg.stored)))
    else $error("state moved with no edge and no preset");

  // clear wins so preset and clear stuck low together still leave a known state
  AST_CLEAR_WINS: assert property (@(posedge clk) disable iff (!rstn)
    (pre_act && clr_act) |=> (!state_reg.stored && !q_true))
    else $error("clear did not win over preset");

  AST_PRESET_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
    (pre_act && !clr_act) |=> state_reg.stored)
    else $error("preset did not set the stored state");

  AST_OUT_FOLLOWS: assert property (@(posedge clk) disable iff (!rstn)
    !(async_act && clk_hi) |=>
      ((q_true == state_reg.stored) && (q_compl != state_reg.stored)))
    else $error("outputs do not follow the stored state");

  AST_RELEASE_SHOWS: assert property (@(posedge clk) disable iff (!rstn)
    seq_async_release |=> (q_true != q_compl))
    else $error("outputs stayed both low after release");

endmodule

// file: bench/gjk_gate_model.sv
`timescale 1ns/100ps
module gjk_gate_model (
  input  wire logic clk,
  output logic      ff_clock,
  output logic      set_gate_a,
  output logic      set_gate_b,
  output logic      set_gate_inv_n,
  output logic      clear_gate_a,
  output logic      clear_gate_b,
  output logic      clear_gate_inv_n,
  output logic      preset_n,
  output logic      clear_n
);
  // idle: clock low, gates low, set and clear released
  initial begin
    ff_clock = 1'h0;
    {clear_gate_inv_n, clear_gate_b, clear_gate_a} = 3'h0;
    {set_gate_inv_n, set_gate_b, set_gate_a} = 3'h0;
    {preset_n, clear_n} = 2'h3;
  end
  task gates(input logic [5:0] g);
    @(posedge clk);
    {clear_gate_inv_n, clear_gate_b, clear_gate_a, set_gate_inv_n, set_gate_b, set_gate_a} <= g;
  endtask
  // gates were settled one cycle earlier; t_jk keeps them put through the high phase, t_lock moves them inside it
  task pulse(input int hi);
    @(posedge clk);
    ff_clock <= 1'h1;
    repeat (hi) @(posedge clk);
    ff_clock <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // hi set means the clock-low rule is broken on purpose
  task pre(input logic p, input logic c, input logic hi);
    @(posedge clk);
    ff_clock <= hi;
    repeat (4) @(posedge clk);
    preset_n <= p;
    clear_n  <= c;
    repeat (5) @(posedge clk);
  endtask
  task idle();
    @(posedge clk);
    {preset_n, clear_n} <= 2'h3;
    ff_clock <= 1'h0;
    repeat (5) @(posedge clk);
  endtask
endmodule

// file: bench/gated_jk_flip_flop_bench.sv
`timescale 1ns/100ps
module gated_jk_flip_flop_bench
  import gjk_pkg::*;
;
  logic clk       = 1'h0;
  logic rstn      = 1'h0;
  int   err_count = 0;
  int   checked   = 0;
  logic s;
  logic q_true;
  logic q_compl;
  wire  ffc, sa, sb, si, ca, cb, ci, pn, cn;
  always #5 clk = ~clk;
  gjk_gate_model partner_u (.clk(clk), .ff_clock(ffc), .set_gate_a(sa), .set_gate_b(sb),
    .set_gate_inv_n(si), .clear_gate_a(ca), .clear_gate_b(cb), .clear_gate_inv_n(ci),
    .preset_n(pn), .clear_n(cn));
  gjk_flip_flop dut_u (.clk(clk), .rstn(rstn), .ff_clock(ffc), .set_gate_a(sa),
    .set_gate_b(sb), .set_gate_inv_n(si), .clear_gate_a(ca), .clear_gate_b(cb),
    .clear_gate_inv_n(ci), .preset_n(pn), .clear_n(cn), .q_true(q_true), .q_compl(q_compl));
  task chk(input logic t, input logic c);
    #1;
    checked++;
    if (q_true !== t || q_compl !== c) begin
      err_count++;
      $display("mismatch q_true,q_compl expected %b%b seen %b%b", t, c, q_true, q_compl);
    end
  endtask
  task t_jk();
    logic [5:0] g [10];
    logic       j;
    logic       k;
    g = '{6'h03, 6'h00, 6'h18, 6'h1b, 6'h1b, 6'h01, 6'h07, 6'h3b, 6'h38, 6'h1f};
    for (int i = 0; i < 10; i++) begin
      j = g[i][0] & g[i][1] & ~g[i][2];
      k = g[i][3] & g[i][4] & ~g[i][5];
      s = (j & k) ? ~s : j ? 1'h1 : k ? 1'h0 : s;
      partner_u.gates(g[i]);
      partner_u.pulse(3);
      chk(s, ~s);
    end
    $display("test jk done");
  endtask
  // a long high phase with gates moving inside it must give one toggle only
  task t_lock();
    partner_u.gates(6'h1b);
    fork
      partner_u.pulse(8);
      begin
        repeat (4) @(posedge clk);
        partner_u.gates(6'h18);
      end
    join
    s = ~s;
    chk(s, ~s);
    repeat (6) @(posedge clk);
    chk(s, ~s);
    $display("test lock done");
  endtask
  task t_async();
    partner_u.pre(1'h1, 1'h0, 1'h0);
    chk(1'h0, 1'h1);
    partner_u.idle();
    partner_u.pre(1'h0, 1'h1, 1'h0);
    chk(1'h1, 1'h0);
    partner_u.idle();
    partner_u.pre(1'h1, 1'h0, 1'h1);
    chk(1'h0, 1'h0);
    partner_u.idle();
    chk(1'h0, 1'h1);
    partner_u.pre(1'h0, 1'h1, 1'h1);
    chk(1'h0, 1'h0);
    partner_u.idle();
    chk(1'h1, 1'h0);
    partner_u.pre(1'h0, 1'h0, 1'h0);
    chk(1'h0, 1'h1);
    partner_u.idle();
    chk(1'h0, 1'h1);
    $display("test async done");
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    s = 1'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    chk(TRUE_RESET, COMPL_RESET);
    $display("test reset done");
    t_jk();
    t_lock();
    t_async();
    summarize();
  end
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule
